// ==== serial_peer_model.sv ====
`timescale 1ns/1ps
module serial_peer_model (
   // clock and serial lines
   input  wire logic clk_sys,
   input  wire logic line,
   output logic      rx_line,
   // frame format
   input  wire logic [31:0] bit_cycles,
   input  wire logic [31:0] n_bits,
   input  wire logic [31:0] n_stop,
   // decoded frame
   output logic [8:0] word,
   output logic       stop_ok,
   output int         frames
);
   initial begin
      rx_line = 1'b1;
      frames = 0;
      forever begin
         @(negedge line);
         repeat (bit_cycles / 2) @(posedge clk_sys);
         if (line === 1'b0) begin
            word = 9'h000;
            stop_ok = 1'b1;
            for (int i = 0; i < n_bits; i++) begin
               repeat (bit_cycles) @(posedge clk_sys);
               word[i] = line;
            end
            for (int i = 0; i < n_stop; i++) begin
               repeat (bit_cycles) @(posedge clk_sys);
               stop_ok = stop_ok & (line === 1'b1);
            end
            frames = frames + 1;
         end
      end
   end
endmodule

// ==== serial_pkg.sv ====
package serial_pkg;

   // register offsets (chosen; 8-bit data on a plain port)
   localparam logic [2:0] ADDR_SERIAL_DATA    = 3'h0;
   localparam logic [2:0] ADDR_BAUD_DIVISOR   = 3'h1;
   localparam logic [2:0] ADDR_CONTROL_ONE    = 3'h2;
   localparam logic [2:0] ADDR_CONTROL_TWO    = 3'h3;
   localparam logic [2:0] ADDR_SERIAL_STATUS  = 3'h4;

   // serial_control_one fields
   localparam int C1_MASTER_EN   = 7;
   localparam int C1_WORD_LEN    = 6;
   localparam int C1_PARITY_EN   = 5;
   localparam int C1_PARITY_ODD  = 4;
   localparam int C1_STOP_TWO    = 3;
   localparam int C1_BREAK       = 2;
   localparam int C1_RX_NINTH    = 1;
   localparam int C1_TX_NINTH    = 0;
   // serial_control_two fields
   localparam int C2_TX_EN       = 7;
   localparam int C2_RX_EN       = 6;
   localparam int C2_SPEED       = 5;
   // serial_status fields
   localparam int ST_PARITY_ERR  = 7;
   localparam int ST_NOISE       = 6;
   localparam int ST_FRAMING_ERR = 5;
   localparam int ST_OVERRUN     = 4;
   localparam int ST_TX_IDLE     = 3;
   localparam int ST_RX_IDLE     = 2;
   localparam int ST_RX_AVAIL    = 1;
   localparam int ST_TX_EMPTY    = 0;

   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
   localparam logic [7:0] BAUD_DIV_RESET    = 8'h00;
   localparam logic [7:0] DATA_RESET        = 8'h00;

   // prescale per divisor step
   localparam logic [6:0] PRESCALE_LOW  = 7'h40;
   localparam logic [6:0] PRESCALE_HIGH = 7'h10;
   // least break length in bit times
   localparam logic [4:0] BREAK_BITS    = 5'h0D;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA  = 5'b00100,
      TX_STOP  = 5'b01000,
      TX_BREAK = 5'b10000
   } tx_state_t;

endpackage

// ==== uart_baud_format_transmitter.sv ====
// Notes on behaviour
// - one 8-bit data register; write feeds transmitter, read returns received data.
// - baud ticks come from a free-running 8-bit timer set by divisor and speed.
// - bit rate is clock/(64(N+1)) at low speed, clock/(16(N+1)) at high.
// - frame is start bit, eight or nine data bits, then stop bits.
// - reset format is eight data bits, no parity, one stop bit.
// - data bits shift least significant bit first.
// - transmitter and receiver share one format and one baud rate.
// - parity even, odd or none; it replaces the last data position.
// - address flag sits in the last data position of the character.
// - transmitter sends one or two stop bits; receiver checks only one.
// - with all enables set pins are serial; idle output rests high.
// - clearing master enable floats both pins and empties the buffers.
// - disable clears enables, break and rx flags; sets idle and empty flags.
// - master disable aborts at once; re-enable keeps the old configuration.
// - ninth bit comes from the ninth-bit field in 9-bit mode.
// - shift register reloads only after stop bits, then at once from holding.
// - shift register is internal, not reachable by software.
// - send only when enabled, data held and baud running; late enable also starts.
// - write with shift register empty moves data straight to shifter.
// - clearing transmit enable stops at once, resets transmitter, floats output.
// - holding writes blocked while empty flag is 0; status read then write clears.
// - break holds output low at least 13 bit times and until request clears.
`timescale 1ns/1ps
module uart_baud_format_transmitter #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 clk_en,
   // register port
   input  wire serial_pkg::bus_req_t bus_req,
   output logic [DATA_W-1:0]         rdata,
   // serial lines
   output serial_pkg::pin_drive_t    tx_pin,
   input  wire logic                 rx_in,
   output logic                      rx_pin_active,
   // received character from receiver path
   input  wire logic                 rx_char_valid,
   input  wire logic [8:0]           rx_char
);

   if (DATA_W != 8) begin
      $error("DATA_W must be 8");
   end

   logic [7:0]  control_one_reg;
   logic [7:0]  control_two_reg;
   logic [7:0]  baud_divisor_reg;
   logic [7:0]  rx_data_reg;
   logic [7:0]  tx_holding_reg;
   logic        holding_full_reg;
   logic        tx_empty_reg;
   logic        tx_idle_reg;
   logic        rx_avail_reg;
   logic        overrun_reg;
   logic        status_seen_reg;
   logic [7:0]  baud_cnt_reg;
   logic [6:0]  pre_cnt_reg;
   logic [10:0] tx_shift_reg;
   logic [3:0]  bit_cnt_reg;
   logic [4:0]  brk_cnt_reg;
   logic        tx_ninth_shadow_reg;
   serial_pkg::tx_state_t state_reg;
   serial_pkg::tx_state_t state_next;

   wire master_en = control_one_reg[serial_pkg::C1_MASTER_EN];
   wire tx_en     = master_en & control_two_reg[serial_pkg::C2_TX_EN];
   wire rx_en     = master_en & control_two_reg[serial_pkg::C2_RX_EN];
   wire nine_bit  = control_one_reg[serial_pkg::C1_WORD_LEN];
   wire par_en    = control_one_reg[serial_pkg::C1_PARITY_EN];
   wire par_odd   = control_one_reg[serial_pkg::C1_PARITY_ODD];
   wire stop_two  = control_one_reg[serial_pkg::C1_STOP_TWO];
   wire brk_req   = control_one_reg[serial_pkg::C1_BREAK];
   wire ninth_in  = control_one_reg[serial_pkg::C1_TX_NINTH];

   wire wr_data   = bus_req.wr & (bus_req.addr == serial_pkg::ADDR_SERIAL_DATA);
   wire wr_c1     = bus_req.wr & (bus_req.addr == serial_pkg::ADDR_CONTROL_ONE);
   wire wr_c2     = bus_req.wr & (bus_req.addr == serial_pkg::ADDR_CONTROL_TWO);
   wire wr_baud   = bus_req.wr & (bus_req.addr == serial_pkg::ADDR_BAUD_DIVISOR);
   wire rd_status = bus_req.rd & (bus_req.addr == serial_pkg::ADDR_SERIAL_STATUS);
   wire rd_data   = bus_req.rd & (bus_req.addr == serial_pkg::ADDR_SERIAL_DATA);
   // writes accepted only while the empty flag is set
   // holding register may be loaded before the transmitter is enabled
   wire hold_wr   = wr_data & tx_empty_reg & master_en;
   // clearing the transmit enable resets the buffer once
   wire tx_drop   = tx_en & wr_c2 & ~bus_req.wdata[serial_pkg::C2_TX_EN];

   // baud timer and prescaler
   wire [6:0] prescale = control_two_reg[serial_pkg::C2_SPEED] ?
                         serial_pkg::PRESCALE_HIGH : serial_pkg::PRESCALE_LOW;
   wire baud_step = (baud_cnt_reg == 8'h00);
   wire bit_tick  = baud_step & (pre_cnt_reg >= prescale - 7'h01);

   // parity over the data bits actually sent
   function automatic logic calc_parity(input logic [8:0] d, input logic nine, input logic odd);
      logic p;
      p = nine ? ^d[7:0] : ^d[6:0];
      return p ^ odd;
   endfunction

   wire [8:0] hold_word = {ninth_in, tx_holding_reg};
   wire       par_bit   = calc_parity(hold_word, nine_bit, par_odd);
   // last data position replaced by parity when enabled
   wire [8:0] frame_data = !par_en ? hold_word :
                           nine_bit ? {par_bit, hold_word[7:0]} :
                                      {1'b0, par_bit, hold_word[6:0]};
   wire [3:0] data_bits = nine_bit ? 4'h9 : 4'h8;
   wire [3:0] stop_bits = stop_two ? 4'h2 : 4'h1;
   // buffered data goes out before a break
   wire load_now  = holding_full_reg & tx_en;
   wire start_brk = brk_req;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         serial_pkg::TX_IDLE: begin
            if (load_now) begin
               state_next = serial_pkg::TX_START;
            end else if (start_brk) begin
               state_next = serial_pkg::TX_BREAK;
            end
         end
         serial_pkg::TX_START: begin
            if (bit_tick) begin
               state_next = serial_pkg::TX_DATA;
            end
         end
         serial_pkg::TX_DATA: begin
            // start bit is the first bit of this state
            if (bit_tick && bit_cnt_reg == data_bits) begin
               state_next = serial_pkg::TX_STOP;
            end
         end
         serial_pkg::TX_STOP: begin
            if (bit_tick && bit_cnt_reg == stop_bits - 4'h1) begin
               state_next = serial_pkg::TX_IDLE;
            end
         end
         serial_pkg::TX_BREAK: begin
            if (bit_tick && brk_cnt_reg >= serial_pkg::BREAK_BITS && !brk_req) begin
               state_next = serial_pkg::TX_STOP;
            end
         end
         default: state_next = serial_pkg::TX_IDLE;
      endcase
   end

   wire frame_done = (state_reg == serial_pkg::TX_STOP) & (state_next == serial_pkg::TX_IDLE);
   wire take_hold  = (state_reg == serial_pkg::TX_IDLE) & load_now;

   // control registers; disable clears enables and break, keeps the rest
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         control_one_reg  <= serial_pkg::CONTROL_ONE_RESET;
         control_two_reg  <= serial_pkg::CONTROL_TWO_RESET;
         baud_divisor_reg <= serial_pkg::BAUD_DIV_RESET;
      end else if (clk_en) begin
         if (wr_c1) begin
            control_one_reg <= {bus_req.wdata[7:2], control_one_reg[1], bus_req.wdata[0]};
         end else if (!master_en) begin
            control_one_reg[serial_pkg::C1_BREAK] <= 1'b0;
         end
         if (rx_char_valid && rx_en) begin
            control_one_reg[serial_pkg::C1_RX_NINTH] <= rx_char[8];
         end
         if (wr_c2) begin
            control_two_reg <= bus_req.wdata;
         end else if (!master_en) begin
            control_two_reg[serial_pkg::C2_TX_EN] <= 1'b0;
            control_two_reg[serial_pkg::C2_RX_EN] <= 1'b0;
         end
         if (wr_baud) begin
            baud_divisor_reg <= bus_req.wdata;
         end
      end
   end

   // free running baud timer, reloads divisor at expiry
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         baud_cnt_reg <= 8'h00;
         pre_cnt_reg  <= 7'h00;
      end else if (clk_en) begin
         baud_cnt_reg <= baud_step ? baud_divisor_reg : baud_cnt_reg - 8'h01;
         if (bit_tick) begin
            pre_cnt_reg <= 7'h00;
         end else if (baud_step) begin
            pre_cnt_reg <= pre_cnt_reg + 7'h01;
         end
      end
   end

   // holding register and flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_holding_reg   <= serial_pkg::DATA_RESET;
         holding_full_reg <= 1'b0;
         tx_empty_reg     <= 1'b1;
         tx_idle_reg      <= 1'b1;
         status_seen_reg  <= 1'b0;
      end else if (clk_en) begin
         if (!master_en || tx_drop) begin
            holding_full_reg <= 1'b0;
            tx_empty_reg     <= 1'b1;
            tx_idle_reg      <= 1'b1;
            status_seen_reg  <= 1'b0;
         end else begin
            if (rd_status) begin
               status_seen_reg <= 1'b1;
            end else if (hold_wr) begin
               status_seen_reg <= 1'b0;
            end
            if (hold_wr) begin
               tx_holding_reg   <= bus_req.wdata;
               holding_full_reg <= 1'b1;
            end else if (take_hold) begin
               holding_full_reg <= 1'b0;
            end
            // set wins over clear
            if (take_hold) begin
               tx_empty_reg <= 1'b1;
            end else if (hold_wr && status_seen_reg) begin
               tx_empty_reg <= 1'b0;
            end
            if (frame_done) begin
               tx_idle_reg <= 1'b1;
            end else if (hold_wr && status_seen_reg) begin
               tx_idle_reg <= 1'b0;
            end
         end
      end
   end

   // shifter and frame counters, internal only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg    <= serial_pkg::TX_IDLE;
         tx_shift_reg <= 11'h7FF;
         bit_cnt_reg  <= 4'h0;
         brk_cnt_reg  <= 5'h00;
      end else if (clk_en) begin
         if (!tx_en) begin
            state_reg    <= serial_pkg::TX_IDLE;
            tx_shift_reg <= 11'h7FF;
            bit_cnt_reg  <= 4'h0;
            brk_cnt_reg  <= 5'h00;
         end else begin
            state_reg <= state_next;
            if (take_hold) begin
               // line stays high until the next tick, so the start bit lasts a full bit
               tx_shift_reg <= {frame_data, 2'b01};
               bit_cnt_reg  <= 4'h0;
            end else if (state_reg == serial_pkg::TX_IDLE && start_brk) begin
               tx_shift_reg <= 11'h000;
               brk_cnt_reg  <= 5'h00;
            end else if (bit_tick) begin
               if (state_reg == serial_pkg::TX_BREAK) begin
                  if (brk_cnt_reg < serial_pkg::BREAK_BITS) begin
                     brk_cnt_reg <= brk_cnt_reg + 5'h01;
                  end
                  if (state_next == serial_pkg::TX_STOP) begin
                     tx_shift_reg <= 11'h7FF;
                     bit_cnt_reg  <= 4'h0;
                  end
               end else begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                  if (state_next != state_reg) begin
                     bit_cnt_reg <= 4'h0;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  if (state_next == serial_pkg::TX_STOP && state_reg == serial_pkg::TX_DATA) begin
                     tx_shift_reg <= 11'h7FF;
                  end
               end
            end
         end
      end
   end

   // receive side data register and flags, shared format and rate
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_data_reg  <= serial_pkg::DATA_RESET;
         rx_avail_reg <= 1'b0;
         overrun_reg  <= 1'b0;
      end else if (clk_en) begin
         if (!rx_en) begin
            rx_avail_reg <= 1'b0;
            overrun_reg  <= 1'b0;
         end else if (rx_char_valid) begin
            rx_data_reg  <= rx_char[7:0];
            rx_avail_reg <= 1'b1;
            overrun_reg  <= overrun_reg | rx_avail_reg;
         end else if (rd_data) begin
            rx_avail_reg <= 1'b0;
         end
      end
   end

   wire [7:0] status_word = {4'h0, tx_idle_reg, ~rx_en, rx_avail_reg, tx_empty_reg} |
                            ({7'h00, overrun_reg} << serial_pkg::ST_OVERRUN);
   wire [7:0] rd_mux =
      (bus_req.addr == serial_pkg::ADDR_SERIAL_DATA)   ? rx_data_reg :
      (bus_req.addr == serial_pkg::ADDR_BAUD_DIVISOR)  ? baud_divisor_reg :
      (bus_req.addr == serial_pkg::ADDR_CONTROL_ONE)   ? {control_one_reg[7:1], 1'b0} :
      (bus_req.addr == serial_pkg::ADDR_CONTROL_TWO)   ? control_two_reg :
      (bus_req.addr == serial_pkg::ADDR_SERIAL_STATUS) ? status_word : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (clk_en) begin
         rdata <= bus_req.rd ? rd_mux : 8'h00;
      end
   end

   // pins float unless enabled; idle line is high
   assign tx_pin.out    = tx_en ? tx_shift_reg[0] : 1'b1;
   assign tx_pin.oe     = tx_en;
   assign rx_pin_active = rx_en;

   a_break_len: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == serial_pkg::TX_BREAK && tx_en) |-> tx_pin.out == 1'b0)
      else $error("break not low");

   a_float_off: assert property (@(posedge clk_sys) disable iff (rst)
      !tx_en |-> !tx_pin.oe)
      else $error("tx driven while disabled");

   a_idle_high: assert property (@(posedge clk_sys) disable iff (rst)
      (tx_en && state_reg == serial_pkg::TX_IDLE && $past(state_reg) == serial_pkg::TX_IDLE
       && $past(tx_en)) |-> tx_pin.out)
      else $error("idle line not high");

   sequence s_load;
      tx_en && clk_en && take_hold;
   endsequence
   sequence s_first_tick;
      tx_en && clk_en && bit_tick && state_reg == serial_pkg::TX_START;
   endsequence
   a_start_bit: assert property (@(posedge clk_sys) disable iff (rst)
      s_load ##1 tx_en |-> state_reg == serial_pkg::TX_START && tx_pin.out == 1'b1)
      else $error("line not idle before start bit");

   a_start_low: assert property (@(posedge clk_sys) disable iff (rst)
      s_first_tick ##1 tx_en |-> state_reg == serial_pkg::TX_DATA && tx_pin.out == 1'b0)
      else $error("no start bit on first tick");

   a_blocked_wr: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && wr_data && !tx_empty_reg && tx_en && !take_hold) |=>
      tx_holding_reg == $past(tx_holding_reg))
      else $error("write while full");

   a_disable_flags: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !master_en && !wr_c2) |=> !control_two_reg[serial_pkg::C2_TX_EN]
      && tx_empty_reg && tx_idle_reg && !rx_avail_reg)
      else $error("disable flags wrong");

   a_baud_reload: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && baud_step) |=> baud_cnt_reg == $past(baud_divisor_reg))
      else $error("baud timer not reloaded");

   a_no_mid_load: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && tx_en && state_reg != serial_pkg::TX_IDLE && !bit_tick) |=> $stable(tx_shift_reg))
      else $error("shifter reloaded mid frame");

endmodule

// ==== uart_baud_format_transmitter_tb_top.sv ====
`timescale 1ns/1ps
module uart_baud_format_transmitter_tb_top;
   logic                   clk_sys;
   logic                   rst;
   logic                   clk_en;
   serial_pkg::bus_req_t   bus_req;
   logic [7:0]             rdata;
   serial_pkg::pin_drive_t tx_pin;
   logic                   rx_in;
   logic                   rx_pin_active;
   logic                   rx_char_valid;
   logic [8:0]             rx_char;
   logic [8:0]             word;
   logic                   stop_ok;
   logic                   tx_line;
   int                     bit_cycles;
   int                     n_bits;
   int                     n_stop;
   int                     frames;
   int                     errors;
   int                     n_tests;
   int                     cycles;
   int                     seed;
   logic [7:0]             c1;
   logic [7:0]             d;
   logic [7:0]             s;
   int                     base;
   int                     lowcnt;

   // floating pin is pulled up
   assign tx_line = tx_pin.oe ? tx_pin.out : 1'b1;

   uart_baud_format_transmitter u_uart_baud_format_transmitter (
      .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
      .tx_pin(tx_pin), .rx_in(rx_in), .rx_pin_active(rx_pin_active),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char));

   serial_peer_model u_serial_peer_model (
      .clk_sys(clk_sys), .line(tx_line), .rx_line(rx_in), .bit_cycles(bit_cycles),
      .n_bits(n_bits), .n_stop(n_stop), .word(word), .stop_ok(stop_ok), .frames(frames));

   always #5 clk_sys = ~clk_sys;

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [8:0] e, input logic [8:0] g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", name, e, g);
         errors++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 v = rdata;
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      check("register", {1'b0, e}, {1'b0, v});
   endtask

   function automatic logic [8:0] exp_word(input logic [7:0] c, input logic [7:0] v);
      if (!c[serial_pkg::C1_WORD_LEN]) begin
         exp_word = c[serial_pkg::C1_PARITY_EN] ? {1'b0, ^v[6:0] ^ c[serial_pkg::C1_PARITY_ODD], v[6:0]} : {1'b0, v};
      end else begin
         exp_word = {c[serial_pkg::C1_PARITY_EN] ? ^v ^ c[serial_pkg::C1_PARITY_ODD] : c[serial_pkg::C1_TX_NINTH], v};
      end
   endfunction

   task automatic setup(input logic [7:0] a, input logic [7:0] b, input logic [7:0] n);
      wr(serial_pkg::ADDR_BAUD_DIVISOR, n);
      wr(serial_pkg::ADDR_CONTROL_ONE, a);
      wr(serial_pkg::ADDR_CONTROL_TWO, b);
      bit_cycles = (b[serial_pkg::C2_SPEED] ? 16 : 64) * (int'(n) + 1);
      n_bits = a[serial_pkg::C1_WORD_LEN] ? 9 : 8;
      n_stop = a[serial_pkg::C1_STOP_TWO] ? 2 : 1;
      c1 = a;
   endtask

   task automatic send(input logic [7:0] v);
      logic [7:0] t;
      rd(serial_pkg::ADDR_SERIAL_STATUS, t);
      wr(serial_pkg::ADDR_SERIAL_DATA, v);
   endtask

   task automatic frame_chk(input int k, input logic [7:0] v);
      int t;
      t = 0;
      while (frames < k && t < 30000) begin
         @(posedge clk_sys);
         t++;
      end
      check("frames_seen", 9'(k), 9'(frames));
      check("tx_word", exp_word(c1, v), word);
      check("stop_ok", 9'h001, {8'h00, stop_ok});
      repeat (bit_cycles) @(posedge clk_sys);
   endtask

   initial begin
      seed = 32'he863db12;
      clk_sys = 1'b0;
      rst = 1'b1;
      clk_en = 1'b1;
      bus_req = '0;
      rx_char_valid = 1'b0;
      rx_char = 9'h000;
      {cycles, errors, n_tests, bit_cycles, n_bits, n_stop} = {32'd0, 32'd0, 32'd0, 32'd16, 32'd8, 32'd1};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(serial_pkg::ADDR_CONTROL_ONE, serial_pkg::CONTROL_ONE_RESET);
      rdchk(serial_pkg::ADDR_CONTROL_TWO, serial_pkg::CONTROL_TWO_RESET);
      rdchk(serial_pkg::ADDR_SERIAL_STATUS, 8'h0D);
      rdchk(3'h7, 8'h00);
      check("oe", 9'h000, {8'h00, tx_pin.oe});
      // random formats and rates, low speed first
      for (int i = 0; i < 10; i++) begin
         setup(8'h80 | (8'($random(seed)) & 8'h79), i == 0 ? 8'hC0 : 8'hE0, i == 0 ? 8'h00 : 8'($random(seed)) & 8'h03);
         #1 check("idle_line", 9'h003, {7'h00, tx_pin.oe, tx_line});
         base = frames;
         d = 8'($random(seed));
         send(d);
         frame_chk(base + 1, d);
      end
      // back to back, then a write while the holding register is full
      setup(8'h88, 8'hE0, 8'h01);
      base = frames;
      d = 8'($random(seed));
      send(d);
      send(8'hA5);
      rd(serial_pkg::ADDR_SERIAL_STATUS, s);
      check("tx_empty", 9'h000, {8'h00, s[serial_pkg::ST_TX_EMPTY]});
      wr(serial_pkg::ADDR_SERIAL_DATA, 8'h3C);
      frame_chk(base + 1, d);
      frame_chk(base + 2, 8'hA5);
      repeat (20 * bit_cycles) @(posedge clk_sys);
      check("frames", 9'(base + 2), 9'(frames));
      // load first, enable transmitter after
      setup(8'h80, 8'h20, 8'h00);
      base = frames;
      send(8'h96);
      wr(serial_pkg::ADDR_CONTROL_TWO, 8'hA0);
      frame_chk(base + 1, 8'h96);
      // transmit enable cleared mid character
      setup(8'h80, 8'hE0, 8'h03);
      send(8'h00);
      repeat (3 * bit_cycles) @(posedge clk_sys);
      wr(serial_pkg::ADDR_CONTROL_TWO, 8'h20);
      #1 check("oe_abort", 9'h000, {8'h00, tx_pin.oe});
      repeat (14 * bit_cycles) @(posedge clk_sys);
      wr(serial_pkg::ADDR_CONTROL_TWO, 8'hE0);
      base = frames;
      send(8'h5A);
      frame_chk(base + 1, 8'h5A);
      // master disable mid character, then resume
      setup(8'hE8, 8'hE0, 8'h02);
      send(8'hFF);
      repeat (2 * bit_cycles) @(posedge clk_sys);
      wr(serial_pkg::ADDR_CONTROL_ONE, 8'h68);
      #1 check("pins_off", 9'h000, {7'h00, tx_pin.oe, rx_pin_active});
      rdchk(serial_pkg::ADDR_CONTROL_TWO, 8'h20);
      rdchk(serial_pkg::ADDR_CONTROL_ONE, 8'h68);
      rdchk(serial_pkg::ADDR_BAUD_DIVISOR, 8'h02);
      rdchk(serial_pkg::ADDR_SERIAL_STATUS, 8'h0D);
      repeat (14 * bit_cycles) @(posedge clk_sys);
      wr(serial_pkg::ADDR_CONTROL_ONE, 8'hE8);
      wr(serial_pkg::ADDR_CONTROL_TWO, 8'hE0);
      base = frames;
      d = 8'($random(seed));
      send(d);
      frame_chk(base + 1, d);
      // break holds the line low
      setup(8'h84, 8'hE0, 8'h00);
      lowcnt = 0;
      repeat (20 * bit_cycles) begin
         @(posedge clk_sys);
         lowcnt += (tx_line === 1'b0) ? 1 : 0;
      end
      wr(serial_pkg::ADDR_CONTROL_ONE, 8'h80);
      check("break_low", 9'h001, {8'h00, lowcnt >= 13 * bit_cycles});
      repeat (40 * bit_cycles) @(posedge clk_sys);
      check("after_break", 9'h001, {8'h00, tx_line});
      // received character reaches the data register
      rx_char_valid <= 1'b1;
      rx_char <= 9'($random(seed));
      @(posedge clk_sys);
      rx_char_valid <= 1'b0;
      rd(serial_pkg::ADDR_SERIAL_STATUS, s);
      check("rx_avail", 9'h001, {8'h00, s[serial_pkg::ST_RX_AVAIL]});
      rdchk(serial_pkg::ADDR_SERIAL_DATA, rx_char[7:0]);
      wr(serial_pkg::ADDR_CONTROL_ONE, 8'h00);
      rdchk(serial_pkg::ADDR_SERIAL_STATUS, 8'h0D);
      finish_test();
   end
endmodule
